// ==== hw/fault_relay_and_signal_loss.sv ====
// Alarm relay driver with delays and analog reference loss detector
//
// Overview of operation
// - Polarity 1 selects normally closed, default.
// - Closed mode energizes coil after powerup delay.
// - Closed mode: trip or power loss de-energizes.
// - Polarity 0: coil energizes only on trip.
// - Open mode ignores power loss.
// - Complementary contacts share one common contact.
// - Relay changes 300 ms after fault; collector instantly.
// - Reference loss stops motor, flag optional.
// - Flag when voltage reference below start threshold.
// - Flag when current reference below 4 mA.
// - Flag clears once reference at or above threshold.
// - Loss is not a trip, never latched.
// - Output terminal function 06 selects loss flag.
`timescale 1ns/100ps

module fault_relay_and_signal_loss
  import relay_pkg::*;
#(
  // Relay timing in clock cycles, below 2**CNT_W; defaults are the real
  // delays, a bench may shorten them to watch whole relay sequences
  parameter int unsigned POWERUP_CYCLES = POWERUP_CYC,
  parameter int unsigned FAULT_CYCLES   = FAULT_DELAY_CYC
)
(
  // Clock and reset
  input  wire logic             MCLK_IN,
  input  wire logic             RST_N_IN,
  // Drive status and relay setting
  input  wire relay_ctl_s       CTL_IN,
  // Analog references, already digitized
  input  wire aref_s            AREF_IN,
  // Intelligent output terminal function code
  input  wire logic [7:0]       TERM_FUNC_IN,
  // Relay contacts: common to closed-idle and open-idle paths
  output logic                  RELAY_COIL_OUT,
  output logic                  RELAY_COMMON_CONTACT_OUT,
  output logic                  RELAY_CLOSED_IDLE_CONTACT_OUT,
  output logic                  RELAY_OPEN_IDLE_CONTACT_OUT,
  // Undelayed open-collector alarm; loss outputs registered one cycle
  output logic                  OC_ALARM_OUT,
  output logic                  SIGNAL_LOSS_FLAG_OUT,
  output logic                  TERM_OUT,
  output logic                  DECEL_REQ_OUT
);

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n;

  // Two stages so release never lands near a clock edge
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rst_meta_q <= 1'h0;
      rst_n      <= 1'h0;
    end else begin
      rst_meta_q <= 1'h1;
      rst_n      <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Fault and loss decode
  // ----------------------------------------------------------------
  logic fault;
  logic loss_now;
  logic closed_mode;

  // Power loss only counts as a fault in normally closed mode
  always_comb begin
    closed_mode = (CTL_IN.relay_pol == POL_NORM_CLOSED);
    fault = CTL_IN.drive_trip
          | (closed_mode & ~CTL_IN.power_ok);
    // Pure compare, no trip path and no latch
    loss_now = (AREF_IN.vref < AREF_IN.start_thr)
             | (AREF_IN.use_iref
                & (AREF_IN.iref_ua < IREF_MIN_UA));
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  state_s s_q;
  state_s s_d;

  // Relay sequencing: powerup wait, fault debounce, alarm hold
  always_comb begin
    s_d      = s_q;
    s_d.loss = loss_now;
    case (s_q.st)
      ST_POWERUP: begin
        s_d.coil = 1'h0;
        if (s_q.cnt == CNT_W'(POWERUP_CYCLES - 1)) begin
          s_d.st  = ST_IDLE;
          s_d.cnt = '0;
        end else begin
          s_d.cnt = s_q.cnt + CNT_W'(1);
        end
      end
      ST_IDLE: begin
        s_d.coil = closed_mode;
        s_d.cnt  = '0;
        if (fault) begin
          s_d.st = ST_DELAY;
        end
      end
      ST_DELAY: begin
        // A fault that clears inside the window never reaches the coil
        if (!fault) begin
          s_d.st  = ST_IDLE;
          s_d.cnt = '0;
        end else if (s_q.cnt == CNT_W'(FAULT_CYCLES - 1)) begin
          s_d.st  = ST_ALARM;
          s_d.cnt = '0;
        end else begin
          s_d.cnt = s_q.cnt + CNT_W'(1);
        end
      end
      ST_ALARM: begin
        s_d.coil = ~closed_mode;
        if (!fault) begin
          s_d.st = ST_IDLE;
        end
      end
      default: begin
        s_d.st  = ST_POWERUP;
        s_d.cnt = '0;
      end
    endcase
  end

  // Register the whole state
  always_ff @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      s_q.st   <= ST_POWERUP;
      s_q.cnt  <= '0;
      s_q.coil <= 1'h0;
      s_q.loss <= 1'h0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Common contact modelled as closed path; either idle contact
  // is the complement of the other
  // The closed-idle contact makes while the coil is energized, so a
  // loop on it reads no alarm in the default polarity and a cut wire
  // still alarms; the open-idle contact makes while the coil rests
  assign RELAY_COIL_OUT                = s_q.coil;
  assign RELAY_COMMON_CONTACT_OUT      = 1'h1;
  assign RELAY_OPEN_IDLE_CONTACT_OUT   = ~s_q.coil;
  assign RELAY_CLOSED_IDLE_CONTACT_OUT = s_q.coil;
  // Open collector follows the fault with no delay
  assign OC_ALARM_OUT                  = fault;
  assign SIGNAL_LOSS_FLAG_OUT          = s_q.loss;
  // Terminal shows the flag only under its function code
  assign TERM_OUT                      = (TERM_FUNC_IN == FUNC_SIGNAL_LOSS)
                                       & s_q.loss;
  // Motor controller decelerates to a stop on loss
  assign DECEL_REQ_OUT                 = s_q.loss;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] up_cnt_q;

  // Helper: cycles since reset release, saturating
  always_ff @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      up_cnt_q <= '0;
    end else if (up_cnt_q != {CNT_W{1'h1}}) begin
      up_cnt_q <= up_cnt_q + CNT_W'(1);
    end
  end

  sequence s_fault_held;
    fault [*8];
  endsequence

  property p_closed_mode;
    @(posedge MCLK_IN) disable iff (!rst_n)
    ($past(s_q.st) == ST_IDLE) |-> (RELAY_COIL_OUT == $past(closed_mode));
  endproperty
  a_closed_mode: assert property (p_closed_mode)
    else $error("Idle coil does not match polarity");

  property p_powerup;
    @(posedge MCLK_IN) disable iff (!rst_n)
    (up_cnt_q < CNT_W'(POWERUP_CYCLES)) |-> !RELAY_COIL_OUT;
  endproperty
  a_powerup: assert property (p_powerup)
    else $error("Coil energized before powerup delay");

  property p_no_early_alarm;
    @(posedge MCLK_IN) disable iff (!rst_n)
    (s_q.st == ST_IDLE) ##1 s_fault_held |-> (s_q.st == ST_DELAY);
  endproperty
  a_no_early_alarm: assert property (p_no_early_alarm)
    else $error("Relay moved before fault delay");

  property p_oc_fast;
    @(posedge MCLK_IN) disable iff (!rst_n)
    CTL_IN.drive_trip |-> OC_ALARM_OUT;
  endproperty
  a_oc_fast: assert property (p_oc_fast)
    else $error("Open collector missed trip");

  property p_open_power;
    @(posedge MCLK_IN) disable iff (!rst_n)
    (!closed_mode && !CTL_IN.drive_trip) |-> !fault;
  endproperty
  a_open_power: assert property (p_open_power)
    else $error("Power loss alarmed in open mode");

  property p_contacts;
    @(posedge MCLK_IN) disable iff (!rst_n)
    RELAY_CLOSED_IDLE_CONTACT_OUT != RELAY_OPEN_IDLE_CONTACT_OUT;
  endproperty
  a_contacts: assert property (p_contacts)
    else $error("Contacts not complementary");

  property p_loss_follow;
    @(posedge MCLK_IN) disable iff (!rst_n)
    rst_n |=> (SIGNAL_LOSS_FLAG_OUT == $past(loss_now));
  endproperty
  a_loss_follow: assert property (p_loss_follow)
    else $error("Loss flag not following compare");

  property p_iref;
    @(posedge MCLK_IN) disable iff (!rst_n)
    (rst_n && AREF_IN.use_iref && AREF_IN.iref_ua < IREF_MIN_UA)
      |=> SIGNAL_LOSS_FLAG_OUT;
  endproperty
  a_iref: assert property (p_iref)
    else $error("Current loss not flagged");

  property p_clear;
    @(posedge MCLK_IN) disable iff (!rst_n)
    (rst_n && !loss_now) |=> !SIGNAL_LOSS_FLAG_OUT;
  endproperty
  a_clear: assert property (p_clear)
    else $error("Loss flag stuck");

  property p_term;
    @(posedge MCLK_IN) disable iff (!rst_n)
    (TERM_FUNC_IN != FUNC_SIGNAL_LOSS) |-> !TERM_OUT;
  endproperty
  a_term: assert property (p_term)
    else $error("Terminal driven without function 06");

  // Relay timing checks; the delays are far longer than any repetition,
  // so the end of each window is found through the counters instead
  // Last counting cycle of the fault window with the fault still there
  sequence s_delay_done;
    (s_q.st == ST_DELAY) && fault
      && (s_q.cnt == CNT_W'(FAULT_CYCLES - 1));
  endsequence

  property p_energize;
    @(posedge MCLK_IN) disable iff (!rst_n)
    (up_cnt_q == CNT_W'(POWERUP_CYCLES + 1))
      |-> (RELAY_COIL_OUT == $past(closed_mode));
  endproperty
  a_energize: assert property (p_energize)
    else $error("Coil not set right after powerup delay");

  property p_alarm_coil;
    @(posedge MCLK_IN) disable iff (!rst_n)
    s_delay_done ##1 fault |=> (RELAY_COIL_OUT == !$past(closed_mode));
  endproperty
  a_alarm_coil: assert property (p_alarm_coil)
    else $error("Coil did not switch when fault delay ran out");

  property p_cancel;
    @(posedge MCLK_IN) disable iff (!rst_n)
    ((s_q.st == ST_DELAY) && !fault) |=> (s_q.st == ST_IDLE);
  endproperty
  a_cancel: assert property (p_cancel)
    else $error("Short fault not dropped");

  property p_alarm_hold;
    @(posedge MCLK_IN) disable iff (!rst_n)
    ((s_q.st == ST_ALARM) && fault) |=> (s_q.st == ST_ALARM);
  endproperty
  a_alarm_hold: assert property (p_alarm_hold)
    else $error("Alarm released while fault present");

  property p_open_idle;
    @(posedge MCLK_IN) disable iff (!rst_n)
    ((s_q.st == ST_IDLE) && !closed_mode) |=> !RELAY_COIL_OUT;
  endproperty
  a_open_idle: assert property (p_open_idle)
    else $error("Open mode coil energized without trip");

  property p_loss_no_trip;
    @(posedge MCLK_IN) disable iff (!rst_n)
    (loss_now && !CTL_IN.drive_trip && CTL_IN.power_ok) |-> !OC_ALARM_OUT;
  endproperty
  a_loss_no_trip: assert property (p_loss_no_trip)
    else $error("Reference loss raised the fault alarm");

endmodule

// ==== hw/relay_pkg.sv ====
// Package with constants and carrier types for the fault relay block
package relay_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 20000000;
  localparam int unsigned POWERUP_MS      = 1500;   // Under 2 s
  localparam int unsigned FAULT_DELAY_MS  = 300;
  localparam int unsigned POWERUP_CYC     = CLK_HZ / 1000 * POWERUP_MS;
  localparam int unsigned FAULT_DELAY_CYC = CLK_HZ / 1000 * FAULT_DELAY_MS;
  localparam int unsigned CNT_W           = 26;

  // ----------------------------------------------------------------
  // Settings and thresholds
  // ----------------------------------------------------------------
  localparam logic       POL_NORM_OPEN   = 1'h0;
  localparam logic       POL_NORM_CLOSED = 1'h1;
  localparam logic [7:0] FUNC_SIGNAL_LOSS = 8'h06;
  localparam int unsigned ADC_W          = 12;
  // Current reference in microamps: 4000 uA is the bottom of 4..20 mA
  localparam logic [15:0] IREF_MIN_UA    = 16'h0FA0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_POWERUP = 2'h0,
    ST_IDLE    = 2'h1,
    ST_DELAY   = 2'h2,
    ST_ALARM   = 2'h3
  } relay_st_e;

  typedef struct packed {
    logic       drive_trip;
    logic       power_ok;
    logic       relay_pol;
  } relay_ctl_s;

  typedef struct packed {
    logic [ADC_W-1:0] vref;
    logic [ADC_W-1:0] start_thr;
    logic [15:0]      iref_ua;
    logic             use_iref;
  } aref_s;

  typedef struct packed {
    relay_st_e        st;
    logic [CNT_W-1:0] cnt;
    logic             coil;
    logic             loss;
  } state_s;

endpackage

// ==== testbench/alarm_loop_model.sv ====
// Model of an external alarm loop wired across two relay contacts
`timescale 1ns/100ps

module alarm_loop_model (
  // Relay contacts seen by the loop
  input  wire logic common_in,
  input  wire logic contact_in,
  // Loop reading
  output logic      alarm_out
);
  // ----------------------------------------------------------------
  // Loop sense
  // ----------------------------------------------------------------
  // An open loop reads as alarm, so a cut wire also alarms
  assign alarm_out = !(common_in && contact_in);
endmodule

// ==== testbench/fault_relay_and_signal_loss_tb.sv ====
// Self-checking testbench for the fault relay and signal loss block
`timescale 1ns/100ps

module fault_relay_and_signal_loss_tb;
  import relay_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic       mclk;
  logic       rst_n;
  relay_ctl_s ctl;
  aref_s      aref;
  logic [7:0] func;
  logic       coil, com, cl_idle, op_idle, oc;
  logic       loss, term, decel, alm_a, alm_b;
  int         miscompares;
  int         num_checks;
  int         cyc;
  // Delays shortened so whole relay sequences fit in a short run; the
  // fault window must be at least eight cycles for the delay assertions
  localparam int unsigned PWRUP_CYC_TB = 200;
  localparam int unsigned FAULT_CYC_TB = 40;

  // ----------------------------------------------------------------
  // Block and alarm loops on both contacts
  // ----------------------------------------------------------------
  fault_relay_and_signal_loss #(
    .POWERUP_CYCLES (PWRUP_CYC_TB),
    .FAULT_CYCLES   (FAULT_CYC_TB)
  ) i_fault_relay_and_signal_loss (
    .MCLK_IN                       (mclk),
    .RST_N_IN                      (rst_n),
    .CTL_IN                        (ctl),
    .AREF_IN                       (aref),
    .TERM_FUNC_IN                  (func),
    .RELAY_COIL_OUT                (coil),
    .RELAY_COMMON_CONTACT_OUT      (com),
    .RELAY_CLOSED_IDLE_CONTACT_OUT (cl_idle),
    .RELAY_OPEN_IDLE_CONTACT_OUT   (op_idle),
    .OC_ALARM_OUT                  (oc),
    .SIGNAL_LOSS_FLAG_OUT          (loss),
    .TERM_OUT                      (term),
    .DECEL_REQ_OUT                 (decel)
  );
  alarm_loop_model i_alarm_loop_model (
    .common_in (com), .contact_in (cl_idle), .alarm_out (alm_a));
  alarm_loop_model i_alarm_loop_model_b (
    .common_in (com), .contact_in (op_idle), .alarm_out (alm_b));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Inputs always change 5 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #5;
  endtask

  // Let the relay delay run out on the present inputs, checking the coil
  // one cycle before and just after the edge on which it is allowed to move
  task automatic hold(input string what, input logic exp_pre,
                      input logic exp_post);
    step(FAULT_CYC_TB + 1);
    chk({what, "_pre"}, exp_pre, coil);
    step(1);
    chk({what, "_post"}, exp_post, coil);
  endtask

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Relay at rest during the power-up wait, contacts complementary
  task automatic t_rest;
    chk("coil", 1'h0, coil);
    chk("common", 1'h1, com);
    chk("closed_idle", 1'h0, cl_idle);
    chk("open_idle", 1'h1, op_idle);
    chk("loop_a", 1'h1, alm_a);
    chk("loop_b", 1'h0, alm_b);
    chk("loss", 1'h0, loss);
  endtask

  // Power loss alarms at once in closed mode only
  task automatic t_power;
    ctl.power_ok = 1'h0;
    #1;
    chk("oc_pwr_closed", 1'h1, oc);
    step(1);
    ctl.relay_pol = POL_NORM_OPEN;
    #1;
    chk("oc_pwr_open", 1'h0, oc);
    step(1);
    ctl = '{1'h0, 1'h1, POL_NORM_CLOSED};
    step(1);
  endtask

  // Coil energizes right after the power-up wait in closed mode and
  // the loop on the closed-idle contact stops reading alarm
  task automatic t_powerup;
    wait (cyc == PWRUP_CYC_TB + 2);
    #5;
    chk("coil_wait", 1'h0, coil);
    chk("loop_a_wait", 1'h1, alm_a);
    step(1);
    chk("coil_up", 1'h1, coil);
    chk("loop_a_up", 1'h0, alm_a);
    chk("loop_b_up", 1'h1, alm_b);
  endtask

  // Closed mode: a fault dropped one cycle before the delay runs out
  // never moves the coil; a trip or a power loss held on opens the loop
  task automatic t_closed;
    ctl.drive_trip = 1'h1;
    #1;
    chk("oc_alarm", 1'h1, oc);
    step(FAULT_CYC_TB);
    ctl.drive_trip = 1'h0;
    #1;
    chk("oc_clear", 1'h0, oc);
    step(2);
    chk("coil_cancel", 1'h1, coil);
    ctl = '{1'h1, 1'h1, POL_NORM_CLOSED};
    hold("trip_nc", 1'h1, 1'h0);
    chk("loop_a_trip", 1'h1, alm_a);
    ctl = '{1'h0, 1'h1, POL_NORM_CLOSED};
    step(2);
    chk("coil_nc_clear", 1'h1, coil);
    ctl = '{1'h0, 1'h0, POL_NORM_CLOSED};
    hold("pwr_nc", 1'h1, 1'h0);
    ctl = '{1'h0, 1'h1, POL_NORM_CLOSED};
    step(2);
    chk("loop_a_clear", 1'h0, alm_a);
  endtask

  // Open mode: coil rests, ignores power loss, energizes on a held trip
  task automatic t_open;
    ctl = '{1'h0, 1'h1, POL_NORM_OPEN};
    step(2);
    chk("coil_no", 1'h0, coil);
    chk("loop_b_no", 1'h0, alm_b);
    ctl = '{1'h0, 1'h0, POL_NORM_OPEN};
    hold("pwr_no", 1'h0, 1'h0);
    ctl = '{1'h1, 1'h1, POL_NORM_OPEN};
    hold("trip_no", 1'h0, 1'h1);
    chk("loop_b_trip", 1'h1, alm_b);
    ctl = '{1'h0, 1'h1, POL_NORM_CLOSED};
    step(2);
    chk("coil_back", 1'h1, coil);
  endtask

  // Loss compares at their boundaries, trip toggled alongside
  task automatic t_loss;
    logic [11:0] v[6] = '{12'h1FF, 12'h201, 12'h100, 12'hFFF, 12'hFFF,
                          12'hFFF};
    logic [15:0] i[6] = '{16'h4E20, 16'h4E20, 16'h4E20, 16'h0F9F,
                          16'h0FA0, 16'h4E20};
    logic        u[6] = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1};
    logic        e[6] = '{1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0};
    for (int k = 0; k < 6; k++) begin
      aref = '{v[k], 12'h200, i[k], u[k]};
      func = k[0] ? 8'h07 : FUNC_SIGNAL_LOSS;
      ctl.drive_trip = k[1];
      step(1);
      chk("loss_flag", e[k], loss);
      chk("decel", e[k], decel);
      chk("term", e[k] & ~k[0], term);
      chk("no_trip", k[1], oc);
    end
    ctl.drive_trip = 1'h0;
    step(1);
  endtask

  // ----------------------------------------------------------------
  // Main sequence, clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'h0;
    rst_n = 1'h0;
    ctl = '{1'h0, 1'h1, POL_NORM_CLOSED};
    aref = '{12'hFFF, 12'h200, 16'h4E20, 1'h0};
    func = FUNC_SIGNAL_LOSS;
    miscompares = 0;
    num_checks = 0;
    step(10);
    rst_n = 1'h1;
    step(3);
    t_rest();
    t_power();
    t_loss();
    t_powerup();
    t_closed();
    t_open();
    // Second reset in mid-run must bring the rest state back
    rst_n = 1'h0;
    step(2);
    rst_n = 1'h1;
    step(3);
    t_rest();
    t_powerup();
    wrap_up();
  end

  always #25 mclk = ~mclk;

  // Cycles since reset release, restarted by every reset
  always @(posedge mclk) cyc <= rst_n ? cyc + 1 : 0;

  // Tests need about 650 cycles, so 5000 is ample
  initial begin
    #(50 * 5000);
    miscompares++;
    wrap_up();
  end
endmodule
